// ### bench/smbus_data_shift_flags_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module smbus_data_shift_flags_asserts
  import smbus_shift_pkg::*;
#(
  parameter int quarter_count = quarter_cycles
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [addr_width-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // bus and interrupt
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic irq
);
  logic en, mst;
  logic [2:0] ie;
  logic [7:0] dat;
  logic [3:0] cnt;
  // shadows of software writes; mst never drops, fine for these runs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en <= 1'b0;
      mst <= 1'b0;
      ie <= 3'h0;
      dat <= 8'h00;
    end else if (wr) begin
      if (addr == addr_ctrl) en <= wdata[ctrl_enable_pos];
      if (addr == addr_ctrl && wdata[ctrl_start_pos]) mst <= 1'b1;
      if (addr == addr_irq_enable) ie <= wdata[2:0];
      if (addr == addr_data) dat <= wdata;
    end
  end
  // scl rises since the last start
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cnt <= 4'h0;
    else if ($fell(sda_in) && scl_in) cnt <= 4'h0;
    else if ($rose(scl_in) && cnt != 4'hf) cnt <= cnt + 4'h1;
  end
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("rdata not idle");
  a_refused_read: assert property (
    rd && addr >= addr_irq_clear |=> rdata == 8'h00)
    else $error("refused read not zero");
  a_data_back: assert property (
    wr && addr == addr_data ##2 rd && addr == addr_data
    |=> rdata == $past(wdata, 3))
    else $error("data readback");
  a_irq_off: assert property (
    wr && addr == addr_irq_enable && wdata[2:0] == 3'h0 |-> ##2 !irq)
    else $error("irq not masked");
  a_msb_first: assert property (
    mst && $rose(scl_in) && cnt < 4'h8
    |-> sda_oe == !dat[3'h7 - cnt[2:0]])
    else $error("wrong bit order");
  a_rx_flag: assert property (
    en && ie[irq_byte_pos] && !mst && $rose(scl_in) && cnt == 4'h7
    |-> ##[1:8] irq)
    else $error("no flag after rx byte");
  a_tx_flag: assert property (
    en && ie[irq_byte_pos] && mst && $rose(scl_in) && cnt == 4'h8
    |-> ##[1:8] irq)
    else $error("no flag after ack");
  a_stop_flag: assert property (
    en && ie[irq_stop_pos] && $rose(sda_in) && scl_in && $past(scl_in)
    |-> ##[1:8] irq)
    else $error("no flag after stop");
  a_open_drain: assert property (!scl_out && !sda_out)
    else $error("line driven high");
endmodule
bind smbus_data_shift_flags smbus_data_shift_flags_asserts #(
  .quarter_count(quarter_count)
) checks (
  .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .irq(irq)
);
`default_nettype wire

// ### bench/smbus_data_shift_flags_test.sv
`timescale 1ns/1ps
`default_nettype none
module smbus_data_shift_flags_test
  import smbus_shift_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [addr_width-1:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  wire logic [7:0] rdata;
  wire logic scl_out, scl_oe, sda_out, sda_oe, irq;
  wire logic p_scl, p_sda, scl, sda;
  int err_total = 0;
  int total_checks = 0;
  // open-drain lines with pull-ups
  assign scl = !(scl_oe || p_scl);
  assign sda = !(sda_oe || p_sda);
  always #25 clk = ~clk;
  // short quarter bit keeps frames brief
  smbus_data_shift_flags #(.quarter_count(4)) DUT (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .scl_in(scl), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .irq(irq));
  smbus_far_node p (.scl(scl), .sda(sda), .scl_pull(p_scl),
    .sda_pull(p_sda));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic get(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask
  // settle past the clearing edge before looking for irq
  task automatic wait_irq;
    int i;
    repeat (3) @(posedge clk);
    for (i = 0; i < 4000 && irq !== 1'b1; i++) @(negedge clk);
    chk({7'h00, irq}, 8'h01);
  endtask
  task automatic do_reset;
    @(posedge clk);
    rstn <= 1'b0;
    p.clear();
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
  endtask
  task automatic t_regs;
    get(addr_data, data_reset);
    get(addr_irq_status, 8'h00);
    put(addr_data, 8'ha5);
    get(addr_data, 8'ha5);
    get(3'h7, 8'h00);
    get(addr_irq_clear, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_master;
    put(addr_irq_enable, 8'h07);
    put(addr_ctrl, 8'h03);
    wait_irq;
    put(addr_data, 8'h96);
    put(addr_irq_clear, 8'h01);
    wait_irq;
    chk(p.got, 8'h96);
    get(addr_data, 8'h96);
    get(addr_irq_status, 8'h01);
    put(addr_ctrl, 8'h05);
    put(addr_irq_clear, 8'h01);
    wait_irq;
    get(addr_irq_status, 8'h05);
    put(addr_irq_enable, 8'h00);
    repeat (2) @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    put(addr_irq_clear, 8'h07);
    get(addr_irq_status, 8'h00);
    $display("test master done");
  endtask
  task automatic t_arb;
    do_reset;
    put(addr_irq_enable, 8'h07);
    put(addr_ctrl, 8'h03);
    wait_irq;
    put(addr_data, 8'hff);
    p.jam = 1'b1;
    put(addr_irq_clear, 8'h01);
    wait_irq;
    get(addr_irq_status, 8'h03);
    get(addr_status, 8'h14);
    get(addr_data, 8'hfe);
    $display("test arbitration done");
  endtask
  // far node holds scl low while the block tries to make a stop
  task automatic t_stop_lost;
    do_reset;
    put(addr_irq_enable, 8'h07);
    put(addr_ctrl, 8'h03);
    wait_irq;
    p.sc = 1'b1;
    put(addr_ctrl, 8'h05);
    put(addr_irq_clear, 8'h01);
    wait_irq;
    get(addr_irq_status, 8'h03);
    get(addr_status, 8'h04);
    $display("test stop arbitration done");
  endtask
  task automatic t_slave;
    do_reset;
    put(addr_irq_enable, 8'h01);
    put(addr_ctrl, 8'h01);
    p.send(8'h4b);
    wait_irq;
    get(addr_data, 8'h4b);
    get(addr_irq_status, 8'h01);
    $display("test slave done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    do_reset;
    t_regs;
    t_master;
    t_arb;
    t_slave;
    t_stop_lost;
    close_out;
  end
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #3000000;
    err_total++;
    close_out;
  end
endmodule
`default_nettype wire

// ### bench/smbus_far_node.sv
`timescale 1ns/1ps
`default_nettype none
module smbus_far_node (
  // resolved lines
  input wire logic scl,
  input wire logic sda,
  // high pulls the line low
  output logic scl_pull,
  output logic sda_pull
);
  logic [7:0] got = 8'h00;
  logic [3:0] n = 4'h0;
  logic jam = 1'b0;
  logic ack = 1'b0;
  logic mst = 1'b0;
  logic sd = 1'b0;
  logic sc = 1'b0;
  assign scl_pull = sc;
  assign sda_pull = jam || ack || sd;
  // a start restarts the bit count
  always @(negedge sda) if (scl) n = 4'h0;
  // capture the line msb first on each of the first eight rises after a start
  always @(posedge scl) begin
    if (n < 4'h8) got = {got[6:0], sda};
    n = n + 4'h1;
  end
  // as slave, ack the ninth bit; changes only while scl is low
  always @(negedge scl) ack = !mst && n == 4'h8;
  task automatic clear;
    jam = 1'b0;
    mst = 1'b0;
    sd = 1'b0;
    sc = 1'b0;
  endtask
  // master frame: start, then eight bits, scl left low
  // offset from the clock edge so the block never samples a moving line
  task automatic send(input logic [7:0] b);
    int i;
    #10 mst = 1'b1;
    sd = 1'b1;
    #400 sc = 1'b1;
    for (i = 7; i >= 0; i--) begin
      #200 sd = !b[i];
      #200 sc = 1'b0;
      #400 sc = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// ### core/smbus_bus_watch.sv
`timescale 1ns/1ps
`default_nettype none
module smbus_bus_watch
  import smbus_shift_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bus line levels
  input wire logic scl_in,
  input wire logic sda_in,
  // decoded bus events
  output bus_events_type ev
);

  logic scl_q;
  logic sda_q;
  logic scl_p;
  logic sda_p;

  // two stages so edges compare like with like
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      scl_p <= scl_q;
      sda_p <= sda_q;
    end
  end

  // start and stop are sda edges while scl stays high
  assign ev.start = sda_p & ~sda_q & scl_p & scl_q;
  assign ev.stop = ~sda_p & sda_q & scl_p & scl_q;
  assign ev.scl_rise = ~scl_p & scl_q;
  assign ev.scl_fall = scl_p & ~scl_q;
  assign ev.scl_hi = scl_q;
  assign ev.sda = sda_q;

endmodule
`default_nettype wire

// ### core/smbus_data_shift_flags.sv
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module smbus_data_shift_flags
  import smbus_shift_pkg::*;
#(
  parameter int quarter_count = quarter_cycles
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [addr_width-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // two-wire bus, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // interrupt
  output logic irq
);

  bus_events_type ev;
  master_state_type state, next_state;
  sda_ctl_type sda_ctl, next_sda_ctl;
  logic [1:0] step, next_step;
  logic next_scl_low, m_scl_low;
  logic start_gen, stop_done, arb_ctrl;
  logic [7:0] serial_byte_buffer;
  logic [3:0] ctrl;
  logic [3:0] bit_cnt;
  logic [irq_width-1:0] irq_status, irq_enable;
  logic master, txmode, active, ack_rx, data_written;
  logic [15:0] div_cnt;

  smbus_bus_watch watch (
    .clk(clk),
    .rstn(rstn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ev(ev)
  );

  // register decode
  wire wr_data = wr && addr == addr_data;
  wire wr_ctrl = wr && addr == addr_ctrl;
  wire wr_ien = wr && addr == addr_irq_enable;
  wire wr_clr = wr && addr == addr_irq_clear;
  wire enable = ctrl[ctrl_enable_pos];
  wire sta = ctrl[ctrl_start_pos];
  wire sto = ctrl[ctrl_stop_pos];
  wire ack_out = ctrl[ctrl_ack_pos];
  wire si = irq_status[irq_byte_pos];
  wire clear_si = wr_clr & wdata[irq_byte_pos];

  // quarter bit time enable for master timing
  wire tick = div_cnt == 16'(quarter_count - 1);

  // shift engine decode
  wire rise_act = ev.scl_rise & active & enable;
  wire data_bit = bit_cnt != ack_bit_index;
  wire arb_data = rise_act & master & txmode & data_bit &
    serial_byte_buffer[7] & ~ev.sda;
  wire arb_ev = arb_data | arb_ctrl;
  wire byte_rx = rise_act & ~txmode & bit_cnt == last_data_index;
  wire byte_tx = rise_act & txmode & ~data_bit;
  wire ack_done_rx = rise_act & ~txmode & ~data_bit;
  wire stop_ev = ev.stop & enable & active;
  wire mode_update = (clear_si & bit_cnt == 4'h0) | ack_done_rx;

  // what the engine wants on sda while scl is low
  wire engine_low = active & ((txmode & data_bit & ~serial_byte_buffer[7]) |
    (~txmode & ~data_bit & ~si & ack_out));
  wire next_sda_oe = (sda_ctl == ctl_low) ? 1'b1 :
    (sda_ctl == ctl_free) ? 1'b0 :
    (ev.scl_hi ? sda_oe : engine_low);
  // slave holds scl low while software handles the byte
  wire next_scl_oe = m_scl_low |
    (~master & active & si & enable & ~ev.scl_hi);

  wire [irq_width-1:0] irq_set;
  assign irq_set[irq_byte_pos] = byte_rx | byte_tx | start_gen |
    stop_ev | arb_ev;
  assign irq_set[irq_arb_pos] = arb_ev;
  assign irq_set[irq_stop_pos] = stop_ev;
  wire [irq_width-1:0] irq_clr = wr_clr ? wdata[irq_width-1:0] : '0;

  wire [7:0] status_word = {bit_cnt, ack_rx, active, txmode, master};
  wire [7:0] read_mux =
    (addr == addr_data) ? serial_byte_buffer :
    (addr == addr_ctrl) ? {4'h0, ctrl} :
    (addr == addr_status) ? status_word :
    (addr == addr_irq_status) ? {5'h00, irq_status} :
    (addr == addr_irq_enable) ? {5'h00, irq_enable} : 8'h00;

  // divider free runs; master steps only on its enable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) div_cnt <= 16'h0000;
    else if (tick) div_cnt <= 16'h0000;
    else div_cnt <= div_cnt + 16'h0001;
  end

  // byte register: software write, else shift on scl rise
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serial_byte_buffer <= data_reset;
    end else if (wr_data) begin
      serial_byte_buffer <= wdata;
    end else if (rise_act & data_bit) begin
      // msb goes out, bus bit comes in at the bottom
      serial_byte_buffer <= {serial_byte_buffer[6:0], ev.sda};
    end
  end

  // bit position within the 9-bit frame
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) bit_cnt <= 4'h0;
    else if (ev.start | ev.stop) bit_cnt <= 4'h0;
    else if (rise_act) bit_cnt <= data_bit ? bit_cnt + 4'h1 : 4'h0;
  end

  // mode flags; a write to the byte register picks send for next byte
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active <= 1'b0;
      master <= 1'b0;
      txmode <= 1'b0;
      ack_rx <= 1'b0;
      data_written <= 1'b0;
    end else begin
      if (ev.start & enable) active <= 1'b1;
      else if (ev.stop) active <= 1'b0;
      if (start_gen) master <= 1'b1;
      else if (arb_ev | stop_done | ~enable) master <= 1'b0;
      if (ev.start | arb_ev) txmode <= 1'b0;
      else if (mode_update) txmode <= data_written;
      if (byte_tx) ack_rx <= ~ev.sda;
      if (wr_data) data_written <= 1'b1;
      else if (mode_update | ev.start) data_written <= 1'b0;
    end
  end

  // control: hardware clears start and stop requests once done
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) ctrl <= ctrl_reset;
    else if (wr_ctrl) ctrl <= wdata[3:0];
    else begin
      if (start_gen | arb_ev) ctrl[ctrl_start_pos] <= 1'b0;
      if (stop_done | arb_ev) ctrl[ctrl_stop_pos] <= 1'b0;
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_status <= '0;
      irq_enable <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
      if (wr_ien) irq_enable <= wdata[irq_width-1:0];
    end
  end

  // master sequencer: start, bit clocking, stop and repeated start
  always_comb begin
    next_state = state;
    next_step = step;
    next_scl_low = m_scl_low;
    next_sda_ctl = sda_ctl;
    start_gen = 1'b0;
    stop_done = 1'b0;
    arb_ctrl = 1'b0;
    unique case (state)
      m_idle: begin
        next_scl_low = 1'b0;
        next_sda_ctl = ctl_data;
        if (enable & sta & ~active & ~si) begin
          next_state = m_start;
          next_step = 2'h0;
          next_sda_ctl = ctl_free;
        end
      end
      m_start: if (tick) begin
        next_step = step + 2'h1;
        if (step == 2'h0) next_sda_ctl = ctl_low;
        else begin
          next_scl_low = 1'b1;
          start_gen = 1'b1;
          next_state = m_wait;
        end
      end
      m_wait: begin
        next_scl_low = 1'b1;
        if (~master) next_state = m_idle;
        else if (~si) begin
          next_step = 2'h0;
          if (sto) next_state = m_stop;
          else if (sta & bit_cnt == 4'h0) next_state = m_restart;
          else begin
            next_state = m_low;
            next_sda_ctl = ctl_data;
          end
        end
      end
      m_low: if (tick) begin
        next_scl_low = 1'b0;
        next_state = m_high;
      end
      m_high: begin
        // waits for the line itself, so slaves may stretch
        if (~master) next_state = m_idle;
        else if (tick & ev.scl_hi) begin
          next_scl_low = 1'b1;
          next_state = si ? m_wait : m_low;
        end
      end
      m_stop: if (tick) begin
        next_step = step + 2'h1;
        if (step == 2'h0) next_sda_ctl = ctl_low;
        else if (step == 2'h1) next_scl_low = 1'b0;
        else if (~ev.scl_hi) begin
          arb_ctrl = 1'b1;
          next_state = m_idle;
        end else begin
          next_sda_ctl = ctl_free;
          stop_done = 1'b1;
          next_state = m_idle;
        end
      end
      m_restart: if (tick) begin
        next_step = step + 2'h1;
        if (step == 2'h0) next_sda_ctl = ctl_free;
        else if (step == 2'h1) next_scl_low = 1'b0;
        else if (step == 2'h2) begin
          if (~ev.scl_hi) begin
            arb_ctrl = 1'b1;
            next_state = m_idle;
          end else next_sda_ctl = ctl_low;
        end else begin
          next_scl_low = 1'b1;
          start_gen = 1'b1;
          next_state = m_wait;
        end
      end
      default: next_state = m_idle;
    endcase
    if (~enable) next_state = m_idle;
  end

  // sequencer state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= m_idle;
      step <= 2'h0;
      m_scl_low <= 1'b0;
      sda_ctl <= ctl_data;
    end else begin
      state <= next_state;
      step <= next_step;
      m_scl_low <= next_scl_low;
      sda_ctl <= next_sda_ctl;
    end
  end

  // registered outputs; open drain so out is always low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      irq <= 1'b0;
    end else begin
      rdata <= rd ? read_mux : 8'h00;
      scl_oe <= next_scl_oe & enable;
      sda_oe <= next_sda_oe & enable;
      irq <= |(irq_status & irq_enable);
    end
  end

endmodule
`default_nettype wire

// ### core/smbus_shift_pkg.sv
package smbus_shift_pkg;

  // register indices on the plain register port
  localparam int addr_width = 3;
  localparam logic [2:0] addr_data = 3'h0;
  localparam logic [2:0] addr_ctrl = 3'h1;
  localparam logic [2:0] addr_status = 3'h2;
  localparam logic [2:0] addr_irq_status = 3'h3;
  localparam logic [2:0] addr_irq_enable = 3'h4;
  localparam logic [2:0] addr_irq_clear = 3'h5;

  // control register fields
  localparam int ctrl_enable_pos = 0;
  localparam int ctrl_start_pos = 1;
  localparam int ctrl_stop_pos = 2;
  localparam int ctrl_ack_pos = 3;
  localparam logic [3:0] ctrl_reset = 4'h0;

  // status register fields
  localparam int stat_master_pos = 0;
  localparam int stat_txmode_pos = 1;
  localparam int stat_active_pos = 2;
  localparam int stat_ackrx_pos = 3;

  // interrupt status / enable / clear fields
  localparam int irq_byte_pos = 0;
  localparam int irq_arb_pos = 1;
  localparam int irq_stop_pos = 2;
  localparam int irq_width = 3;

  localparam logic [7:0] data_reset = 8'h00;
  localparam logic [3:0] ack_bit_index = 4'h8;
  localparam logic [3:0] last_data_index = 4'h7;

  // bus timing: bit period and system clock period in ns
  localparam int bit_time_ns = 10000;
  localparam int clk_period_ns = 50;
  localparam int quarter_cycles = bit_time_ns / (4 * clk_period_ns);

  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic scl_hi;
    logic sda;
  } bus_events_type;

  typedef enum logic [2:0] {
    m_idle = 3'b000,
    m_start = 3'b001,
    m_low = 3'b010,
    m_high = 3'b011,
    m_wait = 3'b100,
    m_stop = 3'b101,
    m_restart = 3'b110
  } master_state_type;

  typedef enum logic [1:0] {
    ctl_data = 2'b00,
    ctl_low = 2'b01,
    ctl_free = 2'b10
  } sda_ctl_type;

endpackage
